// ### hw/meas_trigger_port.sv
/*
 * Measurement sequencer, event lines and half duplex SPI host port.
 * Assumes SPI mode 0 with sclk_i idle low and a frame framed by cs_n_i,
 * open drain event lines pulled up outside, and a signal path that presents
 * its range result on result_i while meas_done_o is high.
 */
// Function
// R1: Free-running starts measurements at programmed rate.
// R2: Free-running pulses ready line low per sample.
// R3: Host reads new sample over SPI.
// R4: Hardware mode idles until trigger line falls.
// R5: Host pulses trigger line low to start.
// R6: Fixed latency from trigger fall to start.
// R7: Trigger and ready lines selectable, same or apart.
// R8: SPI trigger write starts software measurement.
// R9: Software mode pulses ready line when done.
// R10: Host may trigger several devices with one write.
// R11: Range setting sets listening period length.
// R12: Range is one-way distance, doubled for timing.
// R13: SPI data flows one direction at a time.
// R14: MISO driver off unless sending.
// R15: Host ties MISO to MOSI for 3-wire.
// R16: Host gives each device own select, line.
// R17: Host triggers neighbours at precise crystal rate.
// R18: Host feeds crystal clock to slow clock pin.
// R19: Internal slow timebase 30 kHz, external optional.
// R20: Slow timebase sets measurement sample rate.
// R21: Lines released high, low pulses long enough.
// R22: Triggers during a measurement are ignored.
`timescale 1ns/1ps

module meas_trigger_port #(
   parameter logic [ranging_pkg::CM_CNT_W-1:0] CM_RT_CYC =
      ranging_pkg::CM_CNT_W'(ranging_pkg::CM_RT_CYC_DEF)
) (
   // System clock and reset.
   input  wire  logic                  mclk_i,
   input  wire  logic                  nrst_i,
   // SPI host port.
   input  wire  logic                  sclk_i,
   input  wire  logic                  cs_n_i,
   input  wire  logic                  mosi_i,
   output logic                        miso_o,
   output logic                        miso_oe_o,
   // External slow timebase pin.
   input  wire  logic                  slow_timebase_i,
   // Open drain event lines, index 0 is line one, index 1 is line two.
   input  wire  logic [ranging_pkg::NUM_LINES-1:0] event_line_i,
   output logic [ranging_pkg::NUM_LINES-1:0]       event_line_o,
   output logic [ranging_pkg::NUM_LINES-1:0]       event_line_oe_o,
   // Signal path.
   input  wire  logic [15:0]           result_i,
   output logic                        meas_start_o,
   output logic                        listening_o,
   output logic                        meas_done_o
);
   import ranging_pkg::*;

   // ***************************************************************
   // SPI link domain
   // ***************************************************************
   logic [4:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] cmd_r;
   logic [6:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic       wr_tgl_r;
   logic [7:0] tx_r;
   logic       oe_r;
   logic [7:0] rd_byte;
   pub_t       pub_r;

   // The select acts as the frame reset so every frame starts clean.
   wire spi_rst_n = nrst_i & ~cs_n_i;
   wire [7:0] rx_byte = {shift_r[6:0], mosi_i};
   wire is_read = cmd_r[SPI_READ_BIT];

   // Shift in command and data on rising edges.
   always_ff @(posedge sclk_i or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         bit_cnt_r <= 5'h00;
         shift_r   <= 8'h00;
         cmd_r     <= 8'h00;
      end else begin
         if (bit_cnt_r != 5'h10) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
         shift_r <= rx_byte;
         if (bit_cnt_r == 5'h07) begin
            cmd_r <= rx_byte;
         end
      end
   end

   // Write words outlive the frame so the system side reads them stable.
   always_ff @(posedge sclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_addr_r <= 7'h00;
         wr_data_r <= 8'h00;
         wr_tgl_r  <= 1'b0;
      end else if (bit_cnt_r == 5'h0F && !is_read) begin
         wr_addr_r <= cmd_r[6:0];
         wr_data_r <= rx_byte;
         wr_tgl_r  <= ~wr_tgl_r;
      end
   end

   // Read byte selection from the published image, frozen during frames.
   assign rd_byte = (cmd_r[6:0] == ADDR_CTRL)      ? pub_r.ctrl :
                    (cmd_r[6:0] == ADDR_RATE_LO)   ? pub_r.rate[7:0] :
                    (cmd_r[6:0] == ADDR_RATE_HI)   ? pub_r.rate[15:8] :
                    (cmd_r[6:0] == ADDR_FSR)       ? pub_r.full_scale_range :
                    (cmd_r[6:0] == ADDR_STATUS)    ? pub_r.status :
                    (cmd_r[6:0] == ADDR_SAMPLE_LO) ? pub_r.sample[7:0] :
                    (cmd_r[6:0] == ADDR_SAMPLE_HI) ? pub_r.sample[15:8] :
                    (cmd_r[6:0] == ADDR_SEQ)       ? pub_r.seq : 8'h00; // see R3

   // Drive out on falling edges, only during the data phase of a read.
   always_ff @(negedge sclk_i or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         tx_r <= 8'h00;
         oe_r <= 1'b0;
      end else if (bit_cnt_r == 5'h08 && is_read) begin
         tx_r <= rd_byte;
         oe_r <= 1'b1; // see R13
      end else begin
         tx_r <= {tx_r[6:0], 1'b0};
         if (bit_cnt_r == 5'h10) begin
            oe_r <= 1'b0; // see R14
         end
      end
   end

   assign miso_o    = tx_r[7];
   assign miso_oe_o = oe_r; // see R14

   // ***************************************************************
   // Crossings into the system domain
   // ***************************************************************
   logic [1:0] cs_s_r;
   logic [2:0] wr_s_r;
   logic [2:0] ext_s_r;
   logic [2:0] line_s_r [NUM_LINES];
   logic [NUM_LINES-1:0] line_fall;

   // Two stage synchronisers; the write toggle and timebase ones add one history flop for edge detection.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cs_s_r  <= 2'b11;
         wr_s_r  <= 3'b000;
         ext_s_r <= 3'b000;
      end else begin
         cs_s_r  <= {cs_s_r[0], cs_n_i};
         wr_s_r  <= {wr_s_r[1:0], wr_tgl_r};
         ext_s_r <= {ext_s_r[1:0], slow_timebase_i};
      end
   end

   // Each event line gets its own synchroniser and falling edge detector.
   genvar gl;
   generate
      for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
         always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               line_s_r[gl] <= 3'b111;
            end else begin
               line_s_r[gl] <= {line_s_r[gl][1:0], event_line_i[gl]};
            end
         end
         assign line_fall[gl] = line_s_r[gl][2] & ~line_s_r[gl][1];
      end
   endgenerate

   wire wr_take  = wr_s_r[2] ^ wr_s_r[1];
   wire ext_rise = ext_s_r[1] & ~ext_s_r[2];

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   ctrl_t       ctrl_r;
   logic [15:0] rate_r;
   logic [7:0]  fsr_r;

   wire sw_write = wr_take && (wr_addr_r == ADDR_TRIGGER);

   // Host writes land here once the toggle has crossed.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_r <= ctrl_t'(CTRL_RST);
         rate_r <= RATE_RST;
         fsr_r  <= FSR_RST;
      end else if (wr_take) begin
         case (wr_addr_r)
            ADDR_CTRL:    ctrl_r      <= ctrl_t'({3'b000, wr_data_r[4:0]});
            ADDR_RATE_LO: rate_r[7:0] <= wr_data_r;
            ADDR_RATE_HI: rate_r[15:8] <= wr_data_r;
            ADDR_FSR:     fsr_r       <= wr_data_r;
            default:      ctrl_r      <= ctrl_r;
         endcase
      end
   end

   // ***************************************************************
   // Slow timebase and free-running rate
   // ***************************************************************
   logic [11:0] div_r;
   logic [15:0] rate_cnt_r;

   wire int_tick  = (div_r == SLOW_DIV_LAST);
   wire slow_tick = ctrl_r.ext_clk ? ext_rise : int_tick; // see R19
   wire rate_hit  = slow_tick && (rate_cnt_r >= rate_r);

   // Internal divider and the interval counter in slow ticks.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_r      <= 12'h000;
         rate_cnt_r <= 16'h0000;
      end else begin
         div_r <= int_tick ? 12'h000 : div_r + 12'h001;
         if (ctrl_r.mode != MODE_FREE) begin
            rate_cnt_r <= 16'h0000;
         end else if (rate_hit) begin
            rate_cnt_r <= 16'h0000; // see R20
         end else if (slow_tick) begin
            rate_cnt_r <= rate_cnt_r + 16'h0001;
         end
      end
   end

   // ***************************************************************
   // Measurement sequencer
   // ***************************************************************
   meas_st_t              st_r;
   meas_st_t              st_nxt;
   logic [4:0]            lat_r;
   logic [7:0]            unit_r;
   logic [CM_CNT_W-1:0]   cyc_r;
   logic [6:0]            pulse_r;
   logic                  pulse_line_r;
   logic [15:0]           sample_r;
   logic [7:0]            seq_r;

   wire idle     = (st_r == ST_IDLE);
   wire own_hold = (pulse_r != 7'h00) && (pulse_line_r == ctrl_r.trig_line); // see R7
   wire hw_fire  = (ctrl_r.mode == MODE_HW) && line_fall[ctrl_r.trig_line] && !own_hold;
   wire free_fire = (ctrl_r.mode == MODE_FREE) && rate_hit; // see R1
   wire sw_fire  = (ctrl_r.mode == MODE_SW) && sw_write; // see R8
   wire start    = idle && (hw_fire || free_fire || sw_fire); // see R4, see R22
   wire lat_end  = (st_r == ST_LAT) && (lat_r == 5'h00);
   wire cyc_end  = (cyc_r == CM_RT_CYC - CM_CNT_W'(1));
   wire list_end = (st_r == ST_LISTEN) && ((unit_r == 8'h00) || (cyc_end && unit_r == 8'h01));

   // Next state of the sequencer.
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE:   st_nxt = start ? ST_LAT : ST_IDLE;
         ST_LAT:    st_nxt = lat_end ? ST_LISTEN : ST_LAT;
         ST_LISTEN: st_nxt = list_end ? ST_DONE : ST_LISTEN;
         ST_DONE:   st_nxt = ST_IDLE;
         default:   st_nxt = ST_IDLE;
      endcase
   end

   // Latency and listening counters; each range unit costs one round trip.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r   <= ST_IDLE;
         lat_r  <= 5'h00;
         unit_r <= 8'h00;
         cyc_r  <= '0;
      end else begin
         st_r <= st_nxt;
         if (start) begin
            lat_r <= TRIG_LAT_LAST; // see R6
         end else if (st_r == ST_LAT) begin
            lat_r <= lat_r - 5'h01;
         end
         if (lat_end) begin
            unit_r <= fsr_r; // see R11
            cyc_r  <= '0;
         end else if (st_r == ST_LISTEN) begin
            cyc_r <= cyc_end ? '0 : cyc_r + CM_CNT_W'(1); // see R12
            if (cyc_end && unit_r != 8'h00) begin
               unit_r <= unit_r - 8'h01;
            end
         end
      end
   end

   // Result capture and the low pulse on the ready line.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pulse_r      <= 7'h00;
         pulse_line_r <= 1'b0;
         sample_r     <= 16'h0000;
         seq_r        <= 8'h00;
      end else if (st_r == ST_DONE) begin
         pulse_r      <= PULSE_LEN; // see R2, see R9, see R21
         pulse_line_r <= ctrl_r.rdy_line; // see R7
         sample_r     <= result_i;
         seq_r        <= seq_r + 8'h01;
      end else if (pulse_r != 7'h00) begin
         pulse_r <= pulse_r - 7'h01;
      end
   end

   // Open drain drive: low only while pulsing, released high otherwise.
   generate
      for (gl = 0; gl < NUM_LINES; gl++) begin : g_drv
         assign event_line_oe_o[gl] = (pulse_r != 7'h00) && (pulse_line_r == gl); // see R21
         assign event_line_o[gl]    = 1'b0;
      end
   endgenerate

   assign meas_start_o = lat_end;
   assign listening_o  = (st_r == ST_LISTEN);
   assign meas_done_o  = (st_r == ST_DONE);

   // ***************************************************************
   // Published read image
   // ***************************************************************
   // The image only moves while no frame is open, so the link side sees it static.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pub_r <= '0;
      end else if (cs_s_r[1]) begin
         pub_r.ctrl   <= ctrl_r;
         pub_r.rate   <= rate_r;
         pub_r.full_scale_range    <= fsr_r;
         pub_r.status <= {7'h00, !idle};
         pub_r.sample <= sample_r; // see R3
         pub_r.seq    <= seq_r;
      end
   end

endmodule

// ### hw/ranging_pkg.sv
/*
 * Shared constants and types of the measurement trigger and host port block:
 * timing counts, host register offsets, reset values, modes and carriers.
 * Assumes a 100 MHz system clock; every count below is derived from that rate.
 */
package ranging_pkg;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned MCLK_MHZ      = 100;
   localparam int unsigned SLOW_INT_HZ   = 30000;
   localparam int unsigned SLOW_DIV_CYC  = (MCLK_MHZ * 1000000) / SLOW_INT_HZ;
   localparam int unsigned TRIG_LAT_NS   = 200;
   localparam int unsigned TRIG_LAT_CYC  = (TRIG_LAT_NS * MCLK_MHZ + 999) / 1000;
   localparam int unsigned PULSE_NS      = 1000;
   localparam int unsigned PULSE_CYC     = (PULSE_NS * MCLK_MHZ + 999) / 1000;
   localparam int unsigned CM_ONEWAY_NS  = 29155;
   localparam int unsigned CM_RT_CYC_DEF = (2 * CM_ONEWAY_NS * MCLK_MHZ) / 1000;

   localparam logic [11:0] SLOW_DIV_LAST = 12'(SLOW_DIV_CYC - 1);
   localparam logic [4:0]  TRIG_LAT_LAST = 5'(TRIG_LAT_CYC - 1);
   localparam logic [6:0]  PULSE_LEN     = 7'(PULSE_CYC);
   localparam int unsigned CM_CNT_W      = 16;

   // ***************************************************************
   // Host port map, one byte per register
   // ***************************************************************
   localparam logic [6:0] ADDR_CTRL      = 7'h00;
   localparam logic [6:0] ADDR_RATE_LO   = 7'h01;
   localparam logic [6:0] ADDR_RATE_HI   = 7'h02;
   localparam logic [6:0] ADDR_FSR       = 7'h03;
   localparam logic [6:0] ADDR_TRIGGER   = 7'h04;
   localparam logic [6:0] ADDR_STATUS    = 7'h10;
   localparam logic [6:0] ADDR_SAMPLE_LO = 7'h11;
   localparam logic [6:0] ADDR_SAMPLE_HI = 7'h12;
   localparam logic [6:0] ADDR_SEQ       = 7'h13;

   localparam int unsigned SPI_READ_BIT  = 7;
   localparam int unsigned NUM_LINES     = 2;

   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [15:0] RATE_RST      = 16'h0BB8;
   localparam logic [7:0]  FSR_RST       = 8'h64;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      MODE_FREE = 2'b00,
      MODE_HW   = 2'b01,
      MODE_SW   = 2'b10,
      MODE_OFF  = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LAT    = 2'b01,
      ST_LISTEN = 2'b11,
      ST_DONE   = 2'b10
   } meas_st_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       ext_clk;
      logic       rdy_line;
      logic       trig_line;
      mode_t      mode;
   } ctrl_t;

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] rate;
      logic [7:0]  full_scale_range;
      logic [7:0]  status;
      logic [15:0] sample;
      logic [7:0]  seq;
   } pub_t;

endpackage

// ### testbench/host_model.sv
/* Host processor model: SPI controller and trigger pulls on the lines.
   Assumes the bench wires the pulls onto pulled-up event lines. */
`timescale 1ns/1ps

module host_model (
   // System clock and device data out.
   input  wire logic       mclk_i,
   input  wire logic       miso_i,
   input  wire logic       miso_oe_i,
   // SPI controller pins and line pulls.
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic            mosi_o,
   output logic [1:0]      pull_o
);
   // The link clock stands low outside frames.
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      pull_o = 2'b00;
   end

   // One 16 bit frame at 80 ns per bit, then a gap that spaces writes.
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh = {cmd, wd};
      logic        bit_v = 1'b0;
      // Link edges sit 3 ns off the system clock grid, as an unrelated clock would.
      cs_n_o = 1'b0;
      #43;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = (cmd[7] && i < 8) ? ~mosi_o : sh[i];
         #40 sclk_o = 1'b1;
         bit_v = (miso_oe_i === 1'b1) ? miso_i : ~bit_v;
         if (i < 8) rd[i] = bit_v;
         #40 sclk_o = 1'b0;
      end
      #37 cs_n_o = 1'b1;
      #1400;
   endtask

   // Pulls one line low for a number of system clocks.
   task automatic pulse(input int ln, input int len);
      @(posedge mclk_i);
      pull_o[ln] <= 1'b1;
      repeat (len) @(posedge mclk_i);
      pull_o[ln] <= 1'b0;
   endtask
endmodule

// ### testbench/meas_trigger_port_asserts.sv
/* Checker for the trigger and host port block: pulse shapes and orders.
   Assumes it is bound to meas_trigger_port and sees only its ports. */
`timescale 1ns/1ps

module meas_trigger_port_asserts (
   // Clock and reset.
   input  wire logic                              mclk_i,
   input  wire logic                              nrst_i,
   // Watched ports.
   input  wire logic                              cs_n_i,
   input  wire logic                              miso_oe_o,
   input  wire logic [ranging_pkg::NUM_LINES-1:0] event_line_o,
   input  wire logic [ranging_pkg::NUM_LINES-1:0] event_line_oe_o,
   input  wire logic                              meas_start_o,
   input  wire logic                              listening_o,
   input  wire logic                              meas_done_o
);
   import ranging_pkg::*;

   logic [7:0] low_cnt_r;
   logic [7:0] low_cnt_nxt;

   // Counts the cycles that a line has been pulled low.
   assign low_cnt_nxt = (|event_line_oe_o) ? low_cnt_r + 8'h01 : 8'h00;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) low_cnt_r <= 8'h00;
      else low_cnt_r <= low_cnt_nxt;
   end

   logic       busy_r;

   // Marks the span from a start pulse to its done pulse.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) busy_r <= 1'b0;
      else if (meas_start_o) busy_r <= 1'b1;
      else if (meas_done_o) busy_r <= 1'b0;
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   pulse_len_a: assert property ($fell(|event_line_oe_o) |-> low_cnt_r == 8'(PULSE_LEN))
      else $error("event pulse length wrong");
   ready_follow_a: assert property (meas_done_o |=> (|event_line_oe_o))
      else $error("no ready pulse after done");
   one_line_a: assert property ($onehot0(event_line_oe_o))
      else $error("both lines pulled at once");
   drive_low_a: assert property (event_line_o == '0)
      else $error("event line driven high");
   start_pulse_a: assert property (meas_start_o |=> listening_o && !meas_start_o)
      else $error("start pulse shape wrong");
   done_pulse_a: assert property (meas_done_o |=> !meas_done_o)
      else $error("done pulse longer than a cycle");
   miso_off_a: assert property (cs_n_i && $past(cs_n_i) |-> !miso_oe_o)
      else $error("miso driven while deselected");
   no_retrig_a: assert property (meas_start_o |-> !busy_r)
      else $error("start during a measurement");
   done_listen_a: assert property (meas_done_o |-> $past(listening_o))
      else $error("done without listening before");
endmodule

bind meas_trigger_port meas_trigger_port_asserts chk_u (
   .mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .miso_oe_o(miso_oe_o),
   .event_line_o(event_line_o), .event_line_oe_o(event_line_oe_o),
   .meas_start_o(meas_start_o), .listening_o(listening_o), .meas_done_o(meas_done_o));

// ### testbench/tb_measurement_trigger_host_port.sv
/* Self-checking bench of the trigger and host port block.
   Assumes host_model and the bound checker are compiled before it. */
`timescale 1ns/1ps

module tb_measurement_trigger_host_port;
   import ranging_pkg::*;
   logic        mclk;
   logic        nrst_n;
   logic        slow_tb;
   logic [15:0] result;
   logic        sclk, cs_n, mosi, miso, miso_oe, m_start, m_listen, m_done;
   logic [1:0]  pull, ev_out, ev_oe;
   wire  [1:0]  ev_in = ~(ev_oe | pull);
   // Data in and out are shorted into one shared line, as in 3-wire use.
   wire         sdio = (miso_oe === 1'b1) ? miso : mosi;
   int          fails = 0;
   int          n_compared = 0;
   int          n_starts = 0;

   meas_trigger_port #(.CM_RT_CYC(16'h0004)) dut_u (.mclk_i(mclk), .nrst_i(nrst_n),
      .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(sdio), .miso_o(miso), .miso_oe_o(miso_oe),
      .slow_timebase_i(slow_tb), .event_line_i(ev_in), .event_line_o(ev_out),
      .event_line_oe_o(ev_oe), .result_i(result), .meas_start_o(m_start),
      .listening_o(m_listen), .meas_done_o(m_done));
   host_model host_u (.mclk_i(mclk), .miso_i(sdio), .miso_oe_i(miso_oe), .sclk_o(sclk),
      .cs_n_o(cs_n), .mosi_o(mosi), .pull_o(pull));

   // Clock, and a tally of measurement starts.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (m_start === 1'b1) n_starts <= n_starts + 1;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      n_compared++;
      if (got < lo || got > hi) begin
         fails++;
         $display("CHECK FAILED %s exp %0d..%0d got %0d", what, lo, hi, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host_u.xfer({1'b0, a}, d, unused);
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      host_u.xfer({1'b1, a}, 8'h00, d);
   endtask

   // Times one measurement: start latency, listening cycles, ready pulse cycles.
   task automatic measure(input int ln, output int lat, output int lis, output int rdy);
      int w = 0;
      lat = 0;
      lis = 0;
      rdy = 0;
      while (m_start !== 1'b1 && lat < 3000) begin
         @(posedge mclk); #1 lat++;
      end
      // Listening opens one cycle after the start pulse.
      @(posedge mclk); #1;
      while (m_listen === 1'b1 && lis < 3000) begin
         @(posedge mclk); #1 lis++;
      end
      while (ev_oe[ln] !== 1'b1 && w < 5) begin
         @(posedge mclk); #1 w++;
      end
      while (ev_oe[ln] === 1'b1 && rdy < 300) begin
         @(posedge mclk); #1 rdy++;
      end
   endtask

   task automatic t_regs;
      logic [7:0] d;
      rd(ADDR_CTRL, d);      chk("ctrl", {8'h00, CTRL_RST}, {8'h00, d});
      rd(ADDR_RATE_LO, d);   chk("rate lo", {8'h00, RATE_RST[7:0]}, {8'h00, d});
      rd(ADDR_RATE_HI, d);   chk("rate hi", {8'h00, RATE_RST[15:8]}, {8'h00, d});
      rd(ADDR_FSR, d);       chk("fsr", {8'h00, FSR_RST}, {8'h00, d});
      rd(7'h20, d);          chk("unmapped", 16'h0000, {8'h00, d});
      rd(ADDR_STATUS, d);    chk("busy", 16'h0000, {15'h0000, d[0]});
      $display("test regs done");
   endtask

   // Hardware trigger on line one, ready on line two; repeat latency, retrigger.
   task automatic t_hw;
      int l1, l2, lis, rdy, s0;
      logic [7:0] q0, q1, lo, hi;
      wr(ADDR_FSR, 8'h02);
      wr(ADDR_CTRL, 8'h09);
      s0 = n_starts;
      result <= 16'hA5C3;
      repeat (300) @(posedge mclk);
      chk("idle starts", 16'h0000, 16'(n_starts - s0));
      rd(ADDR_SEQ, q0);
      fork host_u.pulse(0, 10); measure(1, l1, lis, rdy); join
      chk_rng("latency", 20, 26, l1);
      chk("listen", 16'h0008, 16'(lis));
      chk("ready", {9'h000, PULSE_LEN}, 16'(rdy));
      fork host_u.pulse(0, 10); measure(1, l2, lis, rdy); join
      chk("repeat latency", 16'(l1), 16'(l2));
      rd(ADDR_SAMPLE_LO, lo);
      rd(ADDR_SAMPLE_HI, hi);
      rd(ADDR_SEQ, q1);
      chk("sample", 16'hA5C3, {hi, lo});
      chk("seq", {8'h00, q0 + 8'h02}, {8'h00, q1});
      wr(ADDR_FSR, 8'h14);
      s0 = n_starts;
      fork
         host_u.pulse(0, 10);
         begin repeat (45) @(posedge mclk); host_u.pulse(0, 10); end
         measure(1, l1, lis, rdy);
      join
      chk("retrigger", 16'h0001, 16'(n_starts - s0));
      $display("test hw done");
   endtask

   // Trigger on line two, ready on the same line and then on line one.
   task automatic t_lines;
      logic [7:0] cfg [2] = '{8'h0D, 8'h05};
      int lat, lis, rdy;
      wr(ADDR_FSR, 8'h03);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL, cfg[k]);
         fork host_u.pulse(1, 10); measure(1 - k, lat, lis, rdy); join
         chk("line ready", {9'h000, PULSE_LEN}, 16'(rdy));
         chk("line listen", 16'h000C, 16'(lis));
      end
      $display("test lines done");
   endtask

   // Software trigger write, then the same write in mode off.
   task automatic t_sw;
      int lat, lis, rdy, s0;
      wr(ADDR_FSR, 8'h01);
      wr(ADDR_CTRL, 8'h02);
      fork wr(ADDR_TRIGGER, 8'h00); measure(0, lat, lis, rdy); join
      chk_rng("sw start", 100, 200, lat);
      chk("sw listen", 16'h0004, 16'(lis));
      chk("sw ready", {9'h000, PULSE_LEN}, 16'(rdy));
      wr(ADDR_CTRL, 8'h03);
      s0 = n_starts;
      wr(ADDR_TRIGGER, 8'h00);
      chk("off starts", 16'h0000, 16'(n_starts - s0));
      $display("test sw done");
   endtask

   // Free running from the external timebase, one start per two ticks.
   task automatic t_free;
      int s0;
      wr(ADDR_FSR, 8'h00);
      wr(ADDR_RATE_LO, 8'h01);
      wr(ADDR_RATE_HI, 8'h00);
      wr(ADDR_CTRL, 8'h10);
      s0 = n_starts;
      for (int k = 0; k < 16; k++) begin
         repeat (50) @(posedge mclk);
         slow_tb <= ~slow_tb;
      end
      repeat (150) @(posedge mclk);
      chk_rng("free starts", 3, 4, n_starts - s0);
      // Internal timebase: one start per two internal ticks, 6666 cycles apart.
      wr(ADDR_CTRL, 8'h00);
      s0 = n_starts;
      repeat (7000) @(posedge mclk);
      chk("int starts", 16'h0001, 16'(n_starts - s0));
      wr(ADDR_CTRL, 8'h03);
      $display("test free done");
   endtask

   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Reset, run the tests in order, and cut a hang short.
   initial begin
      nrst_n = 1'b0;
      slow_tb = 1'b0;
      result = 16'h0000;
      repeat (2) @(posedge mclk);
      nrst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_regs();
      t_hw();
      t_lines();
      t_sw();
      t_free();
      give_verdict();
   end
   initial begin
      #500000;
      fails++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule
